// >>> verilog/crt_pkg.sv
// constants for the 16-bit capture/reload timer: register offsets, bit positions,
// reset values and tick divisors. assumes an 8-bit special-function register port.
package crt_pkg;

	// register offsets on the special-function register port
	localparam logic [7:0] OFS_CONTROL = 8'hc8;
	localparam logic [7:0] OFS_MODE = 8'hc9;
	localparam logic [7:0] OFS_CAP_LOW = 8'hca;
	localparam logic [7:0] OFS_CAP_HIGH = 8'hcb;
	localparam logic [7:0] OFS_COUNT_LOW = 8'hcc;
	localparam logic [7:0] OFS_COUNT_HIGH = 8'hcd;

	// timer_control bit positions
	localparam int CTL_OVERFLOW_FLAG = 7;
	localparam int CTL_EXTERNAL_FLAG = 6;
	localparam int CTL_RECEIVE_BAUD = 5;
	localparam int CTL_TRANSMIT_BAUD = 4;
	localparam int CTL_EXTERNAL_ENABLE = 3;
	localparam int CTL_RUN = 2;
	localparam int CTL_COUNTER_SELECT = 1;
	localparam int CTL_CAPTURE_SELECT = 0;

	// timer_mode bit positions
	localparam int MOD_CLOCK_OUT_ENABLE = 1;
	localparam int MOD_DOWN_COUNT_ENABLE = 0;
	localparam int MOD_WIDTH = 2;

	// reset values and the count maximum
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [1:0] RST_MODE = 2'h0;
	localparam logic [15:0] RST_CAPTURE = 16'h0000;
	localparam logic [15:0] RST_COUNT = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hffff;

	// reserved mode bits read back as this value
	localparam logic [5:0] MOD_RESERVED_READ = 6'h00;

	// internal timer tick divisors chosen by the speed select input
	localparam logic [3:0] DIV_SLOW = 4'hc;
	localparam logic [3:0] DIV_FAST = 4'h4;

endpackage : crt_pkg

// >>> verilog/crt_fall_det.sv
// falling-edge detector for one pin that is already synchronous to the clock.
// assumes the pin changes only relative to sys_clk_i.
`timescale 1ns/1ps
module crt_fall_det (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic pin_i,
	output logic level_o,
	output logic fall_o
);

	logic sample_q;
	logic prev_q;

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			sample_q <= 1'b1;
			prev_q <= 1'b1;
		end else begin
			sample_q <= pin_i;
			prev_q <= sample_q;
		end
	end

	assign level_o = sample_q;
	// sampled high then sampled low
	assign fall_o = prev_q & ~sample_q;

endmodule : crt_fall_det

// >>> verilog/crt_timer.sv
// 16-bit capture/reload timer with up/down count, baud generation and clock output.
// assumes an 8-bit register port from the core and pins synchronous to sys_clk_i.
`timescale 1ns/1ps
module crt_timer (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic sfr_rd_i,
	output logic [7:0] sfr_rdata_o,
	input wire logic trigger_pin_i,
	input wire logic count_pin_i,
	output logic count_pin_o,
	output logic count_pin_oe_o,
	input wire logic timer_speed_select_i,
	input wire logic timer1_overflow_i,
	output logic rx_baud_tick_o,
	output logic tx_baud_tick_o,
	output logic irq_o
);

	logic [7:0] control_q, control_d;
	logic [1:0] mode_q, mode_d;
	logic [15:0] capture_q, capture_d;
	logic [15:0] count_q, count_d;
	logic [3:0] presc_q, presc_d;
	logic half_q;
	logic [7:0] rdata_q;
	logic pin_out_q;
	logic pin_oe_q;
	logic rx_tick_q;
	logic tx_tick_q;
	logic irq_q;

	// pin edge detection, one detector per pin
	logic [1:0] pin_in;
	logic [1:0] pin_level;
	logic [1:0] pin_fall;
	assign pin_in = {count_pin_i, trigger_pin_i};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_pin
			crt_fall_det u_det (
				.sys_clk_i(sys_clk_i),
				.sys_rst_i(sys_rst_i),
				.pin_i(pin_in[gi]),
				.level_o(pin_level[gi]),
				.fall_o(pin_fall[gi])
			);
		end
	endgenerate

	wire trig_level = pin_level[0];
	wire trig_fall = pin_fall[0];
	wire count_fall = pin_fall[1];

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		hit = (addr == ofs);
	endfunction : hit

	// control and mode fields
	wire ovf_flag = control_q[crt_pkg::CTL_OVERFLOW_FLAG];
	wire ext_flag = control_q[crt_pkg::CTL_EXTERNAL_FLAG];
	wire rx_baud = control_q[crt_pkg::CTL_RECEIVE_BAUD];
	wire tx_baud = control_q[crt_pkg::CTL_TRANSMIT_BAUD];
	wire ext_en = control_q[crt_pkg::CTL_EXTERNAL_ENABLE];
	wire run = control_q[crt_pkg::CTL_RUN];
	wire cnt_sel = control_q[crt_pkg::CTL_COUNTER_SELECT];
	wire cap_sel = control_q[crt_pkg::CTL_CAPTURE_SELECT];
	wire clk_oe = mode_q[crt_pkg::MOD_CLOCK_OUT_ENABLE];
	wire down_count_enable = mode_q[crt_pkg::MOD_DOWN_COUNT_ENABLE];

	// register strobes
	wire wr_ctl = sfr_wr_i & hit(sfr_addr_i, crt_pkg::OFS_CONTROL);
	wire wr_mod = sfr_wr_i & hit(sfr_addr_i, crt_pkg::OFS_MODE);
	wire wr_cap_lo = sfr_wr_i & hit(sfr_addr_i, crt_pkg::OFS_CAP_LOW);
	wire wr_cap_hi = sfr_wr_i & hit(sfr_addr_i, crt_pkg::OFS_CAP_HIGH);
	wire wr_cnt_lo = sfr_wr_i & hit(sfr_addr_i, crt_pkg::OFS_COUNT_LOW);
	wire wr_cnt_hi = sfr_wr_i & hit(sfr_addr_i, crt_pkg::OFS_COUNT_HIGH);

	// mode decode
	wire baud_mode = rx_baud | tx_baud;
	wire clkout_mode = clk_oe & ~cnt_sel;
	wire fast_mode = baud_mode | clkout_mode;
	wire reload_mode = baud_mode | ~cap_sel;
	wire updown_mode = ~baud_mode & ~cap_sel & down_count_enable;
	wire count_down = updown_mode & ~trig_level;

	// tick source
	wire [3:0] presc_div = timer_speed_select_i ? crt_pkg::DIV_FAST : crt_pkg::DIV_SLOW;
	wire presc_hit = (presc_q == presc_div - 4'h1);
	wire slow_tick = cnt_sel ? count_fall : presc_hit;
	wire tick = run & (fast_mode ? half_q : slow_tick);

	// roll events
	wire up_roll = tick & ~count_down & (count_q == crt_pkg::COUNT_MAX);
	wire down_roll = tick & count_down & (count_q == capture_q);
	wire roll = up_roll | down_roll;

	// trigger edge actions
	wire ext_edge = trig_fall & ext_en;
	wire edge_capture = ext_edge & ~baud_mode & cap_sel;
	wire edge_reload = ext_edge & ~baud_mode & ~cap_sel & ~down_count_enable;
	wire ext_set = ext_edge & ~updown_mode;

	// next count
	wire [15:0] count_step = count_down ? count_q - 16'h0001 : count_q + 16'h0001;
	always_comb begin
		count_d = count_q;
		if (tick) begin
			count_d = count_step;
		end
		if (up_roll) begin
			count_d = reload_mode ? capture_q : count_step;
		end
		if (down_roll) begin
			count_d = crt_pkg::COUNT_MAX;
		end
		if (edge_reload) begin
			count_d = capture_q;
		end
		if (wr_cnt_lo) begin
			count_d[7:0] = sfr_wdata_i;
		end
		if (wr_cnt_hi) begin
			count_d[15:8] = sfr_wdata_i;
		end
	end

	// next capture/reload value
	always_comb begin
		capture_d = capture_q;
		if (edge_capture) begin
			capture_d = count_q;
		end
		if (wr_cap_lo) begin
			capture_d[7:0] = sfr_wdata_i;
		end
		if (wr_cap_hi) begin
			capture_d[15:8] = sfr_wdata_i;
		end
	end

	// next control: hardware set wins over software write
	wire ovf_set = roll & ~baud_mode;
	wire ext_toggle = roll & updown_mode;
	logic ovf_next;
	logic ext_next;
	always_comb begin
		control_d = wr_ctl ? sfr_wdata_i : control_q;
		ovf_next = control_d[crt_pkg::CTL_OVERFLOW_FLAG] | ovf_set;
		ext_next = control_d[crt_pkg::CTL_EXTERNAL_FLAG];
		if (ext_toggle) begin
			ext_next = ~ext_flag;
		end
		if (ext_set) begin
			ext_next = 1'b1;
		end
		control_d[crt_pkg::CTL_OVERFLOW_FLAG] = ovf_next;
		control_d[crt_pkg::CTL_EXTERNAL_FLAG] = ext_next;
	end

	assign mode_d = wr_mod ? sfr_wdata_i[crt_pkg::MOD_WIDTH-1:0] : mode_q;
	assign presc_d = (presc_hit | ~run | cnt_sel | fast_mode) ? 4'h0 : presc_q + 4'h1;

	// read mux
	wire [7:0] rd_mux =
		hit(sfr_addr_i, crt_pkg::OFS_CONTROL) ? control_q :
		hit(sfr_addr_i, crt_pkg::OFS_MODE) ? {crt_pkg::MOD_RESERVED_READ, mode_q} :
		hit(sfr_addr_i, crt_pkg::OFS_CAP_LOW) ? capture_q[7:0] :
		hit(sfr_addr_i, crt_pkg::OFS_CAP_HIGH) ? capture_q[15:8] :
		hit(sfr_addr_i, crt_pkg::OFS_COUNT_LOW) ? count_q[7:0] :
		hit(sfr_addr_i, crt_pkg::OFS_COUNT_HIGH) ? count_q[15:8] :
		8'h00;

	// interrupt request from flags, gated by mode
	wire ovf_irq = ovf_flag & ~clkout_mode;
	wire ext_irq = ext_flag & ~updown_mode;

	// next values of the half-rate tick and the registered outputs
	wire half_d = run & fast_mode & ~half_q;
	wire pin_out_d = clkout_mode & (roll ? ~pin_out_q : pin_out_q);
	wire rx_tick_d = rx_baud ? roll : timer1_overflow_i;
	wire tx_tick_d = tx_baud ? roll : timer1_overflow_i;
	wire irq_d = ovf_irq | ext_irq;

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			control_q <= crt_pkg::RST_CONTROL;
		end else begin
			control_q <= control_d;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			mode_q <= crt_pkg::RST_MODE;
		end else begin
			mode_q <= mode_d;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			capture_q <= crt_pkg::RST_CAPTURE;
		end else begin
			capture_q <= capture_d;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			count_q <= crt_pkg::RST_COUNT;
		end else begin
			count_q <= count_d;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			presc_q <= 4'h0;
		end else begin
			presc_q <= presc_d;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			half_q <= 1'b0;
		end else begin
			half_q <= half_d;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			rdata_q <= 8'h00;
		end else if (sfr_rd_i) begin
			rdata_q <= rd_mux;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			pin_out_q <= 1'b0;
		end else begin
			pin_out_q <= pin_out_d;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			pin_oe_q <= 1'b0;
		end else begin
			pin_oe_q <= clkout_mode;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			rx_tick_q <= 1'b0;
		end else begin
			rx_tick_q <= rx_tick_d;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			tx_tick_q <= 1'b0;
		end else begin
			tx_tick_q <= tx_tick_d;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

	assign sfr_rdata_o = rdata_q;
	assign count_pin_o = pin_out_q;
	assign count_pin_oe_o = pin_oe_q;
	assign rx_baud_tick_o = rx_tick_q;
	assign tx_baud_tick_o = tx_tick_q;
	assign irq_o = irq_q;

endmodule : crt_timer

// >>> tb/crt_timer_props.sv
// port checker for the capture/reload timer.
// assumes it is bound into crt_timer.
`timescale 1ns/1ps
module crt_timer_props (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic timer1_overflow_i,
	input wire logic count_pin_o,
	input wire logic count_pin_oe_o,
	input wire logic rx_baud_tick_o,
	input wire logic tx_baud_tick_o,
	input wire logic irq_o
);
	logic [5:0] ctl_q;
	logic [1:0] mode_q;
	wire wc = sfr_wr_i && sfr_addr_i == 8'hc8;
	wire clko = mode_q[1] && !ctl_q[1];
	// shadow of the software-only bits
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			ctl_q <= 6'h00;
			mode_q <= 2'h0;
		end else begin
			if (wc) ctl_q <= sfr_wdata_i[5:0];
			if (sfr_wr_i && sfr_addr_i == 8'hc9) mode_q <= sfr_wdata_i[1:0];
		end
	end
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	AST_OE_ON: assert property ($rose(clko) |-> ##[1:2] count_pin_oe_o)
		else $error("clock output not enabled");
	AST_OE_OFF: assert property (!clko [*3] |-> !count_pin_oe_o && !count_pin_o)
		else $error("count pin driven outside clock output");
	AST_RX_T1: assert property (!ctl_q[5] && timer1_overflow_i |=> rx_baud_tick_o)
		else $error("receive tick missing");
	AST_TX_T1: assert property (!ctl_q[4] && timer1_overflow_i |=> tx_baud_tick_o)
		else $error("transmit tick missing");
	AST_BAUD_SAME: assert property (&ctl_q[5:4] && $past(&ctl_q[5:4]) |->
		rx_baud_tick_o == tx_baud_tick_o)
		else $error("baud ticks differ");
	AST_IRQ_SW: assert property (wc && sfr_wdata_i[6] && !mode_q[0] |-> ##2 irq_o)
		else $error("software flag gave no request");
	AST_UD_NOIRQ: assert property (wc && sfr_wdata_i == 8'h40 && mode_q[0] |-> ##2 !irq_o)
		else $error("request from toggling flag");
	AST_RD_MODE: assert property (sfr_rd_i && sfr_addr_i == 8'hc9 |=>
		sfr_rdata_o == {6'h00, $past(mode_q)})
		else $error("mode read wrong");
endmodule : crt_timer_props
bind crt_timer crt_timer_props u_props (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
	.sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i),
	.sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o), .timer1_overflow_i(timer1_overflow_i),
	.count_pin_o(count_pin_o), .count_pin_oe_o(count_pin_oe_o),
	.rx_baud_tick_o(rx_baud_tick_o), .tx_baud_tick_o(tx_baud_tick_o), .irq_o(irq_o));

// >>> tb/crt_pin_model.sv
// far side: trigger and count pins, timer 1 overflow pulses.
// assumes pin levels come from the bench.
`timescale 1ns/1ps
module crt_pin_model (
	input wire logic sys_clk_i,
	input wire logic trig_lvl_i,
	input wire logic cnt_lvl_i,
	input wire logic pin_oe_i,
	input wire logic pin_drv_i,
	output logic trigger_pin_o,
	output logic count_pin_o,
	output logic t1_ovf_o
);
	logic [2:0] div_q = 3'h0;
	assign trigger_pin_o = trig_lvl_i;
	// shared pin: timer wins while enabled
	assign count_pin_o = pin_oe_i ? pin_drv_i : cnt_lvl_i;
	assign t1_ovf_o = div_q == 3'h7;
	always_ff @(posedge sys_clk_i) begin
		div_q <= div_q + 3'h1;
	end
endmodule : crt_pin_model

// >>> tb/tb_crt_timer.sv
// bench for the capture/reload timer.
// assumes crt_timer and crt_pin_model.
`timescale 1ns/1ps
module tb_crt_timer;
	logic sys_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wd = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic trig = 1'b1;
	logic cnt = 1'b1;
	logic spd = 1'b1;
	logic [7:0] rdata;
	logic tpin, cpin, pdrv, poe, t1, rxt, txt, irq;
	int fails = 0;
	int check_count = 0;
	int n;
	always #2 sys_clk_i = ~sys_clk_i;
	crt_pin_model u_pins (.sys_clk_i(sys_clk_i), .trig_lvl_i(trig), .cnt_lvl_i(cnt),
		.pin_oe_i(poe), .pin_drv_i(pdrv), .trigger_pin_o(tpin), .count_pin_o(cpin), .t1_ovf_o(t1));
	crt_timer dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .sfr_addr_i(addr),
		.sfr_wr_i(wr), .sfr_wdata_i(wd), .sfr_rd_i(rd), .sfr_rdata_o(rdata),
		.trigger_pin_i(tpin), .count_pin_i(cpin), .count_pin_o(pdrv), .count_pin_oe_o(poe),
		.timer_speed_select_i(spd), .timer1_overflow_i(t1), .rx_baud_tick_o(rxt),
		.tx_baud_tick_o(txt), .irq_o(irq));
	task automatic finish_test();
		if (fails == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk_i);
		addr = a;
		wd = d;
		wr = 1'b1;
		@(negedge sys_clk_i);
		wr = 1'b0;
	endtask : wreg
	task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
		@(negedge sys_clk_i);
		addr = a;
		rd = 1'b1;
		@(negedge sys_clk_i);
		rd = 1'b0;
		chk({8'h00, rdata}, {8'h00, exp});
	endtask : rreg
	task automatic set16(input logic [7:0] a, input logic [15:0] v);
		wreg(a, v[7:0]);
		wreg(a + 8'h01, v[15:8]);
	endtask : set16
	task automatic get16(input logic [7:0] a, input logic [15:0] v);
		rreg(a, v[7:0]);
		rreg(a + 8'h01, v[15:8]);
	endtask : get16
	task automatic pulse(input int k, input bit on_trig);
		repeat (k) begin
			@(negedge sys_clk_i);
			if (on_trig) trig = 1'b0; else cnt = 1'b0;
			repeat (3) @(negedge sys_clk_i);
			if (on_trig) trig = 1'b1; else cnt = 1'b1;
			repeat (3) @(negedge sys_clk_i);
		end
	endtask : pulse
	task automatic wait_tx();
		n = 0;
		do begin
			@(negedge sys_clk_i);
			n++;
		end while (txt !== 1'b1 && n < 100);
	endtask : wait_tx
	initial begin
		#20000;
		fails++;
		finish_test();
	end
	initial begin
		repeat (10) @(negedge sys_clk_i);
		sys_rst_i = 1'b0;
		for (int i = 0; i < 7; i++) rreg(8'hc8 + 8'(i), 8'h00);
		wreg(8'hc9, 8'hff);
		rreg(8'hc9, 8'h03);
		wreg(8'hc9, 8'h00);
		set16(8'hcc, 16'h1234);
		wreg(8'hc8, 8'h09);
		pulse(1, 1'b1);
		get16(8'hca, 16'h1234);
		rreg(8'hc8, 8'h49);
		chk(16'(irq), 16'h0001);
		wreg(8'hc8, 8'h01);
		pulse(1, 1'b1);
		rreg(8'hc8, 8'h01);
		chk(16'(irq), 16'h0000);
		set16(8'hca, 16'habcd);
		wreg(8'hc8, 8'h08);
		pulse(1, 1'b1);
		get16(8'hcc, 16'habcd);
		rreg(8'hc8, 8'h48);
		set16(8'hcc, 16'hfffe);
		wreg(8'hc8, 8'h06);
		pulse(2, 1'b0);
		get16(8'hcc, 16'habcd);
		rreg(8'hc8, 8'h86);
		wreg(8'hc8, 8'h02);
		pulse(3, 1'b0);
		get16(8'hcc, 16'habcd);
		wreg(8'hc9, 8'h01);
		set16(8'hca, 16'h0005);
		set16(8'hcc, 16'h0006);
		trig = 1'b0;
		wreg(8'hc8, 8'h06);
		pulse(2, 1'b0);
		get16(8'hcc, 16'hffff);
		rreg(8'hc8, 8'hc6);
		trig = 1'b1;
		pulse(1, 1'b0);
		get16(8'hcc, 16'h0005);
		rreg(8'hc8, 8'h86);
		wreg(8'hc8, 8'h40);
		repeat (2) @(negedge sys_clk_i);
		chk(16'(irq), 16'h0000);
		wreg(8'hc9, 8'h00);
		wreg(8'hc8, 8'h40);
		repeat (2) @(negedge sys_clk_i);
		chk(16'(irq), 16'h0001);
		set16(8'hca, 16'hfff0);
		set16(8'hcc, 16'hfffe);
		wreg(8'hc8, 8'h35);
		wait_tx();
		chk(16'(rxt), 16'h0001);
		wait_tx();
		chk(16'(n), 16'h0020);
		rreg(8'hc8, 8'h35);
		wreg(8'hc8, 8'h00);
		wreg(8'hc9, 8'h02);
		set16(8'hcc, 16'hfffe);
		wreg(8'hc8, 8'h04);
		repeat (10) @(negedge sys_clk_i);
		chk(16'(poe), 16'h0001);
		chk(16'(cpin), 16'h0001);
		chk(16'(irq), 16'h0000);
		wreg(8'hc8, 8'h00);
		wreg(8'hc9, 8'h00);
		// internal ticks at both speeds: stop lands on the 40th clock after run
		for (int s = 0; s < 2; s++) begin
			spd = (s == 0);
			set16(8'hcc, 16'h0000);
			wreg(8'hc8, 8'h04);
			repeat (38) @(negedge sys_clk_i);
			wreg(8'hc8, 8'h00);
			get16(8'hcc, 16'(40 / (s == 0 ? crt_pkg::DIV_FAST : crt_pkg::DIV_SLOW)));
		end
		finish_test();
	end
endmodule : tb_crt_timer
